// *** rtl/trig_io_cfg.svh ***
// constants for trigger conditioning, output line selection and stream pacing
// Summary of operation
// [R1] trigger and output polarity selectable, default negative
// [R2] external trigger pulse held at least 200us
// [R3] each output line picks one internal source
// [R4] sampled trigger passes anti-chatter filter first
// [R5] trigger recognised 0.625 to 1.625 sample periods
// [R6] no trigger while frame-trigger-wait is inactive
// [R7] image data sent as packet stream, frame-wise
// [R8] packet delay between packets, block start delay
// [R9] frames repeat at period; burst from formula
// [R10] burst at least 100us mono, 250us colour
// [R11] width mode follows trigger; timed mode counts
// [R12] new level accepted only when observed unchanged
`ifndef TRIG_IO_CFG_SVH
`define TRIG_IO_CFG_SVH

`define CLK_MHZ             125
`define MIN_TRIG_PULSE_US   200
`define BURST_MIN_MONO_US   100
`define BURST_MIN_COLOUR_US 250
`define BURST_MIN_MONO_CYC   (`BURST_MIN_MONO_US * `CLK_MHZ)
`define BURST_MIN_COLOUR_CYC (`BURST_MIN_COLOUR_US * `CLK_MHZ)
`define CONFIRM_NUM         5
`define CONFIRM_SHIFT       3
`define PKT_OVERHEAD        16'h0024
`define DEF_PACKET_SIZE     16'h05dc
`define POL_NEGATIVE        1'b0
`define FIFO_DEPTH          8
`define DIV_STEPS           6'h32

`endif

// *** rtl/trig_io_pkg.sv ***
// types shared by the trigger and stream timing block
package trig_io_pkg;
  typedef enum logic [2:0] {
    SRC_VDRIVE     = 3'h0,
    SRC_TIMER_ZERO = 3'h1,
    SRC_EXPOSURE   = 3'h2,
    SRC_FRAME      = 3'h3,
    SRC_TRANSFER   = 3'h4,
    SRC_TRIG_WAIT  = 3'h5
  } out_src_t;

  typedef enum logic {
    EXP_TIMED = 1'b0,
    EXP_WIDTH = 1'b1
  } exp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_EXPOSE    = 3'h1,
    ST_BLOCK_DLY = 3'h2,
    ST_SEND      = 3'h3,
    ST_GAP       = 3'h4
  } frame_state_t;
endpackage

// *** rtl/anti_chatter.sv ***
// trigger sampler with anti-chatter confirmation
`timescale 1ns/1ns
`include "trig_io_cfg.svh"
module anti_chatter #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  // level and sampling
  input  wire logic                levelIn,
  input  wire logic [SAMPLE_W-1:0] sampleInterval,
  // clean level
  output logic                     levelOut
);
  logic [SAMPLE_W-1:0] phase;
  logic                held;
  logic                clean;
  wire  [SAMPLE_W+2:0] scaled   = {3'h0, sampleInterval} * (SAMPLE_W+3)'(`CONFIRM_NUM);
  wire  [SAMPLE_W-1:0] rawPoint = scaled[SAMPLE_W+2:`CONFIRM_SHIFT];
  wire  [SAMPLE_W-1:0] confirmAt = (rawPoint == '0) ? SAMPLE_W'(1) : rawPoint;
  wire                 periodEnd = ({1'b0, phase} + 1'b1) >= {1'b0, sampleInterval};
  wire                 atSample  = (phase == '0);
  wire                 atConfirm = (phase == confirmAt);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= '0;
    end else if (periodEnd) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // [R12] sample then watch for change
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      held  <= 1'b0;
      clean <= 1'b0;
    end else if (atSample) begin
      held  <= levelIn;
      clean <= 1'b1;
    end else if (levelIn != held) begin
      clean <= 1'b0;
    end
  end

  // [R4] [R5] accept 5/8 period after sample
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      levelOut <= 1'b0;
    end else if (atConfirm && !atSample && clean && levelIn == held) begin
      levelOut <= held;
    end
  end

  change_at_confirm_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R5]
    !$stable(levelOut) |-> $past(atConfirm))
    else $error("clean trigger changed away from confirm point");
  stable_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R12]
    !$stable(levelOut) |-> $past(clean) && $past(levelIn) == levelOut)
    else $error("clean trigger took an unsettled level");
endmodule

// *** rtl/stream_fifo.sv ***
// small synchronous fifo in the pixel path
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= doWrite ? ((wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1) : wrPtr;
      rdPtr <= doRead ? ((rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1) : rdPtr;
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule

// *** rtl/trigger_io_stream_timing.sv ***
// trigger conditioning, output line sources and frame stream pacing
`timescale 1ns/1ns
`include "trig_io_cfg.svh"
module trigger_io_stream_timing #(
  parameter int          WIDTH            = 32,
  parameter int          FIFO_DEPTH       = `FIFO_DEPTH,
  parameter int          SAMPLE_W         = 16,
  parameter int unsigned BURST_MONO_CYC   = `BURST_MIN_MONO_CYC,
  parameter int unsigned BURST_COLOUR_CYC = `BURST_MIN_COLOUR_CYC
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  // configuration
  input  wire logic                cfgLoad,
  input  wire logic                cfgTrigPolarity,
  input  wire logic [1:0]          cfgOutPolarity,
  input  wire logic [2:0]          cfgPushSource,
  input  wire logic [2:0]          cfgIsoSource,
  input  wire logic                triggerEnable,
  input  wire logic                exposureMode,
  input  wire logic [31:0]         exposureCycles,
  input  wire logic [SAMPLE_W-1:0] triggerSampleInterval,
  input  wire logic [31:0]         framePeriodCycles,
  input  wire logic [31:0]         blockStartDelay,
  input  wire logic [31:0]         packetDelay,
  input  wire logic [15:0]         packetSize,
  input  wire logic [31:0]         payloadSize,
  input  wire logic                colourModel,
  // trigger pin and status sources
  input  wire logic                trigPin,
  input  wire logic                timerZeroRunning,
  // pixel input
  input  wire logic [WIDTH-1:0]    pixData,
  input  wire logic                pixValid,
  output logic                     pixReady,
  // packet stream output
  output logic      [WIDTH-1:0]    txData,
  output logic                     txValid,
  input  wire logic                txReady,
  output logic                     txLast,
  output logic                     txFrameEnd,
  // output lines
  output logic                     pushPullOutputLine,
  output logic                     isolatedOutputLineOut,
  output logic                     isolatedOutputLineOe,
  // status
  output logic                     burstBusy
);
  localparam int BYTES = WIDTH / 8;
  localparam int BSH   = $clog2(BYTES);

  logic                       trigPol;
  logic [1:0]                 outPol;
  trig_io_pkg::out_src_t      pushSrc;
  trig_io_pkg::out_src_t      isoSrc;
  trig_io_pkg::frame_state_t  state;
  trig_io_pkg::frame_state_t  next_state;
  logic                       trigFilt;
  logic                       trigPrev;
  logic [31:0]                periodCnt;
  logic [31:0]                timer;
  logic [31:0]                slotCnt;
  logic [15:0]                pktCnt;
  logic [31:0]                frameLeft;
  logic                       vdPulse;
  logic [49:0]                divNum;
  logic [32:0]                divRem;
  logic [31:0]                divDen;
  logic [5:0]                 divCnt;
  logic [31:0]                burstFormula;
  logic                       fifoValid;
  logic [WIDTH-1:0]           fifoData;

  // [R1] polarity and source latches, negative at reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigPol <= `POL_NEGATIVE;
      outPol  <= {2{`POL_NEGATIVE}};
      pushSrc <= trig_io_pkg::SRC_VDRIVE;
      isoSrc  <= trig_io_pkg::SRC_VDRIVE;
    end else if (cfgLoad) begin
      trigPol <= cfgTrigPolarity;
      outPol  <= cfgOutPolarity;
      pushSrc <= trig_io_pkg::out_src_t'(cfgPushSource);
      isoSrc  <= trig_io_pkg::out_src_t'(cfgIsoSource);
    end
  end

  // [R1] active when pin level matches polarity
  wire trigActive = ~(trigPin ^ trigPol);

  anti_chatter #(
    .SAMPLE_W (SAMPLE_W)
  ) u_filter (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .levelIn        (trigActive),
    .sampleInterval (triggerSampleInterval),
    .levelOut       (trigFilt)
  );

  stream_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .inData   (pixData),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (txReady && state == trig_io_pkg::ST_SEND)
  );

  // frame control decode
  wire        trigRise   = trigFilt && !trigPrev;
  wire        frameTick  = (periodCnt == '0);
  wire        inIdle     = (state == trig_io_pkg::ST_IDLE);
  wire        inSend     = (state == trig_io_pkg::ST_SEND);
  wire        inGap      = (state == trig_io_pkg::ST_GAP);
  wire        widthMode  = triggerEnable && (exposureMode == trig_io_pkg::EXP_WIDTH);
  wire        startFrame = inIdle && (triggerEnable ? trigRise : frameTick);
  wire [32:0] elapsed    = {1'b0, timer} + 33'h1;
  wire        expTimeUp  = elapsed >= {1'b0, exposureCycles};
  wire        dlyUp      = elapsed >= {1'b0, blockStartDelay};
  wire        gapUp      = elapsed >= {1'b0, packetDelay};
  wire [31:0] minBurst   = colourModel ? 32'(BURST_COLOUR_CYC) : 32'(BURST_MONO_CYC);
  wire [31:0] burstTgt   = (burstFormula > minBurst) ? burstFormula : minBurst;
  wire        slotUp     = ({1'b0, slotCnt} + 33'h1) >= {1'b0, burstTgt};
  wire [15:0] pktBytes   = packetSize - `PKT_OVERHEAD;
  wire [15:0] pktWords   = pktBytes >> BSH;
  wire        pktLast    = ({1'b0, pktCnt} + 17'h1) >= {1'b0, pktWords};
  wire        frameLast  = frameLeft <= 32'(BYTES);
  wire        txFire     = txValid && txReady;
  wire        expDone    = widthMode ? !trigFilt : expTimeUp;

  // [R7] payload words leave as packets
  assign txValid    = inSend && fifoValid;
  assign txData     = fifoData;
  assign txLast     = inSend && (pktLast || frameLast);
  assign txFrameEnd = inSend && frameLast;
  assign burstBusy  = inSend || inGap;

  always_comb begin
    next_state = state;
    case (state)
      trig_io_pkg::ST_IDLE: begin
        if (startFrame) begin
          next_state = trig_io_pkg::ST_EXPOSE;
        end
      end
      // [R11] width follows trigger, timed counts
      trig_io_pkg::ST_EXPOSE: begin
        if (expDone) begin
          next_state = trig_io_pkg::ST_BLOCK_DLY;
        end
      end
      // [R8] block start delay
      trig_io_pkg::ST_BLOCK_DLY: begin
        if (dlyUp) begin
          next_state = trig_io_pkg::ST_SEND;
        end
      end
      trig_io_pkg::ST_SEND: begin
        if (txFire && txLast) begin
          next_state = frameLast ? trig_io_pkg::ST_IDLE : trig_io_pkg::ST_GAP;
        end
      end
      // [R8] [R10] packet delay and burst spacing
      trig_io_pkg::ST_GAP: begin
        if (gapUp && slotUp) begin
          next_state = trig_io_pkg::ST_SEND;
        end
      end
      default: begin
        next_state = trig_io_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= trig_io_pkg::ST_IDLE;
      trigPrev <= 1'b0;
      vdPulse  <= 1'b0;
    end else begin
      state    <= next_state;
      trigPrev <= trigFilt;
      vdPulse  <= startFrame;
    end
  end

  // [R9] free-running frame period
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periodCnt <= '0;
    end else begin
      periodCnt <= frameTick ? framePeriodCycles - 32'h1 : periodCnt - 32'h1;
    end
  end

  // cycles spent in the current state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer <= '0;
    end else begin
      timer <= (state != next_state) ? '0 : timer + 32'h1;
    end
  end

  // packet slot, word and byte counters
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slotCnt   <= '0;
      pktCnt    <= '0;
      frameLeft <= '0;
    end else begin
      slotCnt   <= (next_state == trig_io_pkg::ST_SEND && !inSend) ? '0 : slotCnt + 32'h1;
      pktCnt    <= !inSend ? '0 : (txFire ? pktCnt + 16'h1 : pktCnt);
      frameLeft <= startFrame ? payloadSize : (txFire ? frameLeft - 32'(BYTES) : frameLeft);
    end
  end

  // [R9] burst = 3 * period * (size - 36) / payload
  wire [32:0] remShift = {divRem[31:0], divNum[49]};
  wire        remFits  = remShift >= {1'b0, divDen};
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divNum       <= '0;
      divRem       <= '0;
      divDen       <= '0;
      divCnt       <= '0;
      burstFormula <= '0;
    end else if (cfgLoad) begin
      divNum <= 50'(framePeriodCycles * 50'h3 * 50'(pktBytes));
      divRem <= '0;
      divDen <= payloadSize;
      divCnt <= `DIV_STEPS;
    end else if (divCnt != '0) begin
      divNum <= {divNum[48:0], remFits};
      divRem <= remFits ? remShift - {1'b0, divDen} : remShift;
      divCnt <= divCnt - 6'h1;
    end else begin
      burstFormula <= (divNum[49:32] != '0) ? 32'hffffffff : divNum[31:0];
    end
  end

  // [R3] source selection per line
  wire [5:0] srcVec  = {triggerEnable && inIdle, burstBusy, !inIdle,
                        state == trig_io_pkg::ST_EXPOSE, timerZeroRunning, vdPulse};
  wire       pushSel = (pushSrc <= trig_io_pkg::SRC_TRIG_WAIT) ? srcVec[pushSrc] : 1'b0;
  wire       isoSel  = (isoSrc <= trig_io_pkg::SRC_TRIG_WAIT) ? srcVec[isoSrc] : 1'b0;
  wire       pushLvl = ~(pushSel ^ outPol[0]);
  wire       isoLvl  = ~(isoSel ^ outPol[1]);

  // [R1] [R3] registered lines; open collector pulls low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pushPullOutputLine   <= 1'b1;
      isolatedOutputLineOe <= 1'b0;
    end else begin
      pushPullOutputLine   <= pushLvl;
      isolatedOutputLineOe <= ~isoLvl;
    end
  end
  assign isolatedOutputLineOut = 1'b0;

  sequence sentLastWord;
    txValid && txReady && txLast && frameLast;
  endsequence

  line_follows_src_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R3]
    ##1 pushPullOutputLine == $past(pushLvl) && isolatedOutputLineOe == $past(~isoLvl))
    else $error("output line not following selected source");
  pol_held_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R1]
    !cfgLoad |=> $stable(trigPol) && $stable(outPol))
    else $error("polarity changed without load");
  timed_expose_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R11]
    state == trig_io_pkg::ST_EXPOSE && !widthMode && next_state != state
      |-> elapsed >= {1'b0, exposureCycles} && (timer == '0 || timer + 32'h1 == exposureCycles))
    else $error("timed exposure length wrong");
  width_expose_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R11]
    state == trig_io_pkg::ST_EXPOSE && widthMode && !trigFilt |=> state == trig_io_pkg::ST_BLOCK_DLY)
    else $error("width exposure outlived trigger");
  block_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R8]
    state == trig_io_pkg::ST_BLOCK_DLY ##1 state == trig_io_pkg::ST_SEND
      |-> $past(elapsed) >= {1'b0, blockStartDelay})
    else $error("block start delay too short");
  packet_gap_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R10]
    inGap ##1 inSend |-> $past(elapsed) >= {1'b0, packetDelay} && $past(slotCnt) + 32'h1 >= $past(burstTgt))
    else $error("packet spacing too short");
  frame_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R7]
    sentLastWord |=> inIdle)
    else $error("frame did not end after last word");
  frame_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R9]
    inIdle && !triggerEnable && frameTick |=> state == trig_io_pkg::ST_EXPOSE ##0 vdPulse)
    else $error("free-run frame did not start on period");
endmodule

// *** sim/trig_stream_partner.sv ***
// far-side model: trigger source and packet stream receiver
`timescale 1ns/1ns
module trig_stream_partner #(
  parameter int MIN_W = 40,
  parameter int PKT_W = 4
) (
  // clock
  input  wire logic        ref_clk,
  // trigger source
  output logic             trigPin,
  // stream sink
  input  wire logic [31:0] txData,
  input  wire logic        txValid,
  output logic             txReady,
  input  wire logic        txLast,
  input  wire logic        txFrameEnd,
  input  wire logic        stallOn
);
  int unsigned cyc        = 0;
  int unsigned expData    = 0;
  int unsigned badData    = 0;
  int unsigned badLast    = 0;
  int unsigned lastCount  = 0;
  int unsigned frameEnds  = 0;
  int unsigned minSpacing = '1;
  int unsigned minGap     = '1;
  int unsigned startCyc   = 0;
  int unsigned endCyc     = 0;
  int unsigned wordIdx    = 0;
  bit          inPkt      = 0;
  bit          seenPkt    = 0;

  initial begin
    trigPin = 1'b1;
    txReady = 1'b0;
  end

  always @(negedge ref_clk) begin
    txReady <= ~stallOn | cyc[1];
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (txValid === 1'b1 && txReady) begin
      if (txData !== expData) badData <= badData + 1;
      expData <= expData + 1;
      if (!inPkt && seenPkt) begin
        if (cyc - startCyc < minSpacing) minSpacing <= cyc - startCyc;
        if (cyc - endCyc < minGap) minGap <= cyc - endCyc;
      end
      if (!inPkt) startCyc <= cyc;
      inPkt <= ~txLast;
      if (txFrameEnd ? !txLast : ((wordIdx == PKT_W - 1) != txLast)) badLast <= badLast + 1;
      wordIdx <= txLast ? 0 : wordIdx + 1;
      if (txLast) lastCount <= lastCount + 1;
      if (txLast) endCyc <= cyc;
      seenPkt <= ~txFrameEnd;
      if (txFrameEnd) frameEnds <= frameEnds + 1;
    end
  end

  task automatic clear();
    badData    = 0;
    badLast    = 0;
    lastCount  = 0;
    minSpacing = '1;
    minGap     = '1;
  endtask

  task automatic idle(input logic lvl);
    trigPin = lvl;
  endtask

  // pulse held at least MIN_W cycles unless glitch, fired at the next negedge without waiting
  task automatic pulse(input logic act, input int unsigned width, input bit glitch);
    int unsigned w;
    w = (glitch || width >= MIN_W) ? width : MIN_W;
    @(negedge ref_clk);
    trigPin = act;
    repeat (w) @(negedge ref_clk);
    trigPin = ~act;
  endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for trigger conditioning, output lines and packet pacing
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [2:0] src;
    logic       pol;
    logic       tz;
    logic       push;
    logic       oe;
  } row_t;
  localparam row_t ROWS [11] = '{
    '{3'h1, 1'b1, 1'b1, 1'b1, 1'b0}, '{3'h1, 1'b1, 1'b0, 1'b0, 1'b1},
    '{3'h1, 1'b0, 1'b1, 1'b0, 1'b1}, '{3'h1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{3'h7, 1'b1, 1'b1, 1'b0, 1'b1}, '{3'h6, 1'b0, 1'b1, 1'b1, 1'b0},
    '{3'h0, 1'b1, 1'b1, 1'b0, 1'b1}, '{3'h2, 1'b1, 1'b1, 1'b0, 1'b1},
    '{3'h5, 1'b1, 1'b0, 1'b1, 1'b0}, '{3'h3, 1'b0, 1'b0, 1'b1, 1'b0},
    '{3'h4, 1'b1, 1'b0, 1'b0, 1'b1}};

  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cfgLoad = 1'b0;
  logic        trigPol = 1'b0;
  logic [1:0]  outPol = 2'h0;
  logic [2:0]  pushSrc = 3'h0;
  logic [2:0]  isoSrc = 3'h0;
  logic        expMode = 1'b0;
  logic [31:0] payload = 32'h28;
  logic        colour = 1'b0;
  logic        tz = 1'b0;
  logic        pixValid = 1'b0;
  logic [31:0] pixCnt = 32'h0;
  logic        stallOn = 1'b1;
  logic        trigEn = 1'b1;
  logic [31:0] expCyc = 32'h32, frmPer = 32'hc8, blkDly = 32'ha, pktDly = 32'h5;
  logic [15:0] sampIv = 16'h10, pktSize = 16'h34;
  logic        pixReady, txValid, txReady, txLast, txFrameEnd, pushLine, isoOut, isoOe, busy, trigPin;
  logic [31:0] txData;
  int unsigned errCount = 0;
  int unsigned numChecks = 0;
  int unsigned lat, len, n;

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (pixValid && pixReady) pixCnt <= pixCnt + 32'h1;
  end

  trigger_io_stream_timing #(.BURST_MONO_CYC(20), .BURST_COLOUR_CYC(40)) i_trigger_io_stream_timing (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfgLoad(cfgLoad), .cfgTrigPolarity(trigPol),
    .cfgOutPolarity(outPol), .cfgPushSource(pushSrc), .cfgIsoSource(isoSrc), .triggerEnable(trigEn),
    .exposureMode(expMode), .exposureCycles(expCyc), .triggerSampleInterval(sampIv),
    .framePeriodCycles(frmPer), .blockStartDelay(blkDly), .packetDelay(pktDly), .packetSize(pktSize),
    .payloadSize(payload), .colourModel(colour), .trigPin(trigPin), .timerZeroRunning(tz),
    .pixData(pixCnt), .pixValid(pixValid), .pixReady(pixReady), .txData(txData), .txValid(txValid),
    .txReady(txReady), .txLast(txLast), .txFrameEnd(txFrameEnd), .pushPullOutputLine(pushLine),
    .isolatedOutputLineOut(isoOut), .isolatedOutputLineOe(isoOe), .burstBusy(busy));

  trig_stream_partner i_trig_stream_partner (
    .ref_clk(ref_clk), .trigPin(trigPin), .txData(txData), .txValid(txValid), .txReady(txReady),
    .txLast(txLast), .txFrameEnd(txFrameEnd), .stallOn(stallOn));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic loadCfg(input int unsigned w);
    @(negedge ref_clk);
    cfgLoad = 1'b1;
    @(negedge ref_clk);
    cfgLoad = 1'b0;
    repeat (w) @(negedge ref_clk);
  endtask

  task automatic resetVals();
    check({pixReady, txValid, txLast, txFrameEnd, busy}, 32'h10);
    check({pushLine, isoOe, isoOut}, 32'h4);
  endtask

  task automatic measure(output int unsigned l, output int unsigned d);
    @(negedge ref_clk);
    l = 0;
    while (pushLine !== 1'b1 && l < 200) begin
      @(negedge ref_clk);
      l++;
    end
    d = 0;
    while (pushLine === 1'b1 && d < 400) begin
      @(negedge ref_clk);
      d++;
    end
  endtask

  task automatic shot(input logic act, input int unsigned w, input bit g);
    fork
      i_trig_stream_partner.pulse(act, w, g);
      measure(lat, len);
    join
  endtask

  task automatic waitFrame(input int unsigned k);
    n = 0;
    while (i_trig_stream_partner.frameEnds != k && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    check(32'(i_trig_stream_partner.frameEnds), k);
    check(32'(i_trig_stream_partner.badData), 32'h0);
    check(32'(i_trig_stream_partner.badLast), 32'h0);
    check(32'(i_trig_stream_partner.minGap >= 5), 32'h1);
  endtask

  initial begin
    #(8 * 40000);
    errCount++;
    results();
  end

  initial begin
    repeat (11) @(negedge ref_clk);
    resetVals();
    @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 11; i++) begin
      tz = ROWS[i].tz;
      pushSrc = ROWS[i].src;
      isoSrc = ROWS[i].src;
      outPol = {2{ROWS[i].pol}};
      loadCfg(3);
      check({pushLine, isoOe, isoOut}, {29'h0, ROWS[i].push, ROWS[i].oe, 1'b0});
    end
    pixValid = 1'b1;
    repeat (12) @(negedge ref_clk);
    check({pixCnt[30:0], pixReady}, 32'h10);
    pushSrc = 3'h2;
    outPol = 2'h1;
    loadCfg(60);
    shot(1'b0, 60, 1'b0);
    check(32'(lat >= 10 && lat <= 29), 32'h1);
    check(32'(len >= 49 && len <= 51), 32'h1);
    waitFrame(1);
    check(32'(i_trig_stream_partner.lastCount), 32'h3);
    check(32'(i_trig_stream_partner.minSpacing >= 240), 32'h1);
    i_trig_stream_partner.idle(1'b0);
    trigPol = 1'b1;
    loadCfg(60);
    shot(1'b1, 3, 1'b1);
    check(32'(lat), 32'd200);
    expMode = 1'b1;
    shot(1'b1, 100, 1'b0);
    check(32'(lat >= 10 && lat <= 29), 32'h1);
    check(32'(len >= 82 && len <= 118), 32'h1);
    waitFrame(2);
    expMode = 1'b0;
    payload = 32'h190;
    colour = 1'b1;
    stallOn = 1'b0;
    loadCfg(60);
    i_trig_stream_partner.clear();
    shot(1'b1, 60, 1'b0);
    check(32'(lat >= 10 && lat <= 29), 32'h1);
    check(32'(len >= 49 && len <= 51), 32'h1);
    waitFrame(3);
    check(32'(i_trig_stream_partner.lastCount), 32'd25);
    check(32'(i_trig_stream_partner.minSpacing >= 40), 32'h1);
    shot(1'b1, 60, 1'b0);
    n = 0;
    while (busy !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    check(32'(busy), 32'h1);
    waitFrame(4);
    // free run: frames start from the period counter
    trigEn = 1'b0;
    waitFrame(5);
    check(32'(i_trig_stream_partner.lastCount), 32'd75);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    resetVals();
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check({pushLine, isoOe}, 32'h2);
    @(negedge ref_clk);
    check({pushLine, isoOe}, 32'h1);
    results();
  end
endmodule
